// >>> rtl/dfs_pkg.sv
// Purpose: shared constants and carriers for the drive fault supervisor
// Assumes: 100 MHz mclk, percentages in tenths, times in tenths of a second
// Notes: action digits are held one per nibble, so 0x22222 reads as 22222
package dfs_pkg;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [25:0] PCT_FULL = 26'd1000;
  localparam logic [9:0] LL_CUT_PM = 10'd70;
  // register byte offsets
  localparam logic [7:0] OFF_ACT1 = 8'h00;
  localparam logic [7:0] OFF_ACT2 = 8'h04;
  localparam logic [7:0] OFF_ACT3 = 8'h08;
  localparam logic [7:0] OFF_ACT4 = 8'h0c;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_STBY = 8'h14;
  localparam logic [7:0] OFF_TEMP = 8'h18;
  localparam logic [7:0] OFF_LL = 8'h1c;
  localparam logic [7:0] OFF_OS = 8'h20;
  localparam logic [7:0] OFF_DEV = 8'h24;
  localparam logic [7:0] OFF_IRQ_STS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h2c;
  localparam logic [7:0] OFF_STATE = 8'h30;
  // field positions
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_SENS_LSB = 4;
  localparam int CFG_LLEN_BIT = 8;
  localparam int TIME_LSB = 16;
  localparam int WARN_LSB = 8;
  // reset values
  localparam logic [19:0] RST_ACT = 20'h00000;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [1:0] RST_SENS = 2'h0;
  localparam logic RST_LLEN = 1'b0;
  localparam logic [9:0] RST_STBY = 10'd1000;
  localparam logic [7:0] RST_OH_FAULT = 8'd110;
  localparam logic [7:0] RST_OH_WARN = 8'd90;
  localparam logic [9:0] RST_LL_LEVEL = 10'd100;
  localparam logic [9:0] RST_LL_TIME = 10'd10;
  localparam logic [9:0] RST_OS_MARGIN = 10'd200;
  localparam logic [9:0] RST_OS_TIME = 10'd10;
  localparam logic [9:0] RST_DEV_MARGIN = 10'd200;
  localparam logic [9:0] RST_DEV_TIME = 10'd50;
  localparam int NFAULT = 16;
  localparam int NEV = 6;

  typedef enum logic [1:0] {
    ACT_COAST = 2'b00,
    ACT_STOP = 2'b01,
    ACT_RUN = 2'b10
  } dfs_act_t;

  typedef enum logic [2:0] {
    SEL_CUR = 3'b000,
    SEL_SET = 3'b001,
    SEL_UPPER = 3'b010,
    SEL_LOWER = 3'b011,
    SEL_STBY = 3'b100
  } dfs_sel_t;

  typedef enum logic {
    LL_IDLE = 1'b0,
    LL_CUT = 1'b1
  } dfs_ll_t;

  // frequencies in 0.01 Hz, current in permille of rated, temp in degC
  typedef struct packed {
    logic [7:0] temp;
    logic [9:0] current;
    logic [15:0] speed;
    logic [15:0] set_freq;
    logic [15:0] run_freq;
    logic [15:0] max_freq;
    logic [15:0] upper_freq;
    logic [15:0] lower_freq;
    logic [15:0] rated_freq;
  } dfs_meas_t;

  typedef struct packed {
    logic motor_overload_fault;
    logic input_phase_loss_fault;
    logic output_phase_loss_fault;
    logic external_fault;
    logic comm_fault;
    logic nvm_fault;
    logic run_time_expired_fault;
    logic user_fault_one;
    logic user_fault_two;
    logic power_on_time_expired_fault;
    logic pid_feedback_lost_fault;
    logic initial_position_fault;
  } dfs_fault_in_t;
endpackage

// >>> rtl/dfs_supervisor.sv
// Behaviour
// R1: each action digit picks coast stop, method stop, or keep running.
// R2: group one digits: overload, input phase, output phase, external, comm.
// R3: group two: tens nvm, ten-thousands run time; others reserved; reset 0.
// R4: group three: user one, user two, power-on time, load loss, pid loss.
// R5: group four: deviation, overspeed, initial position, load loss.
// R6: keep-running frequency selector 0..4, default current frequency.
// R7: standby frequency is tenths of percent of maximum, default 100.0.
// R8: sensor type 0 none, 1 and 2 resistive elements, default 0.
// R9: overheat fault when temperature exceeds threshold, default 110 C.
// R10: overheat warning output while temperature exceeds warning level.
// R11: load loss cuts frequency to 7 percent rated after persistence.
// R12: when load returns during load loss, resume at set frequency; the code resumes at the frequency chosen by sel_q (default current).
// R13: overspeed fault when speed passes max plus margin for the time.
// R14: zero overspeed time disables overspeed detection.
// R15: deviation fault when speed departs set frequency too long.
// R16: zero deviation time disables deviation detection.
// R17: persistence timers clear whenever their condition drops.
// Purpose: fault action resolution and protection detectors, APB registers
// Assumes: measurements and fault levels come from logic on mclk
// Notes: overheat, overspeed and deviation faults latch until fault_clear; load loss releases when load returns
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module dfs_persist
  import dfs_pkg::*;
#(
  parameter int W = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // timing
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  input wire logic zero_off,
  output logic expired
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (srst || !cond) begin
      cnt_q <= '0; // [R17]
    end else if (tick && cnt_q < limit) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // a limit lowered mid-count still expires instead of wrapping
  assign expired = cond && cnt_q >= limit && !(zero_off && limit == '0);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  timer_clear_a: assert property (!cond |=> cnt_q == '0) // [R17]
    else $error("persistence count survived a dropped condition");
  timer_step_a: assert property ( // [R13]
    cond && tick && cnt_q < limit |=> cnt_q == $past(cnt_q) + W'(1))
    else $error("persistence count did not advance on tick");
endmodule

module dfs_supervisor
  import dfs_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side
  input wire dfs_meas_t meas,
  input wire dfs_fault_in_t faults,
  input wire logic fault_clear,
  // responses
  output logic coast_stop,
  output logic method_stop,
  output logic keep_running,
  output logic freq_ovr_valid,
  output logic [15:0] freq_ovr,
  output logic overheat_warn,
  output logic irq
);
  logic [19:0] act_q [4];
  logic [2:0] sel_q;
  logic [1:0] sens_q;
  logic ll_en_q;
  logic [9:0] stby_q, ll_lvl_q, ll_time_q, os_mar_q, os_time_q;
  logic [9:0] dev_mar_q, dev_time_q;
  logic [7:0] oh_thr_q, warn_thr_q;
  logic [NEV-1:0] sts_q, msk_q, ev;
  logic [2:0] det_q;
  dfs_ll_t ll_q;
  logic [11:0] flt_prev_q;
  logic [31:0] tick_cnt_q;
  logic tick, ll_cond, os_cond, dev_cond, oh_cond, warn_cond;
  logic ll_exp, os_exp, dev_exp;
  logic [15:0] os_off, dev_off, dev, stby_f, ll_f;
  logic [NFAULT-1:0] active;
  dfs_act_t code [NFAULT];
  logic any_coast, any_stop, any_run;
  logic wr, rd_ok;

  function automatic logic [15:0] pct_of(input logic [15:0] f,
                                         input logic [9:0] p);
    logic [25:0] prod;
    prod = 26'(f) * 26'(p);
    return 16'(prod / PCT_FULL);
  endfunction

  // digits above 2 fall back to coast, the safest reading
  function automatic dfs_act_t digit(input logic [19:0] v, input int i);
    logic [3:0] d;
    d = v[4*i +: 4];
    case (d)
      4'h1: return ACT_STOP;
      4'h2: return ACT_RUN;
      default: return ACT_COAST;
    endcase
  endfunction

  // apb: zero wait state, error on unmapped offsets
  assign wr = psel && penable && pwrite;
  assign pready = psel && penable;
  assign rd_ok = paddr <= OFF_STATE && paddr[1:0] == 2'b00;
  assign pslverr = pready && !rd_ok;

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int g = 0; g < 4; g++) begin
        act_q[g] <= RST_ACT; // [R3]
      end
      sel_q <= RST_SEL; // [R6]
      sens_q <= RST_SENS; // [R8]
      ll_en_q <= RST_LLEN;
      stby_q <= RST_STBY; // [R7]
      oh_thr_q <= RST_OH_FAULT; // [R9]
      warn_thr_q <= RST_OH_WARN; // [R10]
      ll_lvl_q <= RST_LL_LEVEL;
      ll_time_q <= RST_LL_TIME;
      os_mar_q <= RST_OS_MARGIN;
      os_time_q <= RST_OS_TIME;
      dev_mar_q <= RST_DEV_MARGIN;
      dev_time_q <= RST_DEV_TIME;
      msk_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFF_ACT1: act_q[0] <= pwdata[19:0];
        OFF_ACT2: act_q[1] <= pwdata[19:0];
        OFF_ACT3: act_q[2] <= pwdata[19:0];
        OFF_ACT4: act_q[3] <= pwdata[19:0];
        OFF_CFG: begin
          sel_q <= pwdata[CFG_SEL_LSB +: 3];
          sens_q <= pwdata[CFG_SENS_LSB +: 2];
          ll_en_q <= pwdata[CFG_LLEN_BIT];
        end
        OFF_STBY: stby_q <= pwdata[9:0];
        OFF_TEMP: begin
          oh_thr_q <= pwdata[7:0];
          warn_thr_q <= pwdata[WARN_LSB +: 8];
        end
        OFF_LL: begin
          ll_lvl_q <= pwdata[9:0];
          ll_time_q <= pwdata[TIME_LSB +: 10];
        end
        OFF_OS: begin
          os_mar_q <= pwdata[9:0];
          os_time_q <= pwdata[TIME_LSB +: 10];
        end
        OFF_DEV: begin
          dev_mar_q <= pwdata[9:0];
          dev_time_q <= pwdata[TIME_LSB +: 10];
        end
        OFF_IRQ_MSK: msk_q <= pwdata[NEV-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = '0;
    case (paddr)
      OFF_ACT1: prdata[19:0] = act_q[0];
      OFF_ACT2: prdata[19:0] = act_q[1];
      OFF_ACT3: prdata[19:0] = act_q[2];
      OFF_ACT4: prdata[19:0] = act_q[3];
      OFF_CFG: begin
        prdata[CFG_SEL_LSB +: 3] = sel_q;
        prdata[CFG_SENS_LSB +: 2] = sens_q;
        prdata[CFG_LLEN_BIT] = ll_en_q;
      end
      OFF_STBY: prdata[9:0] = stby_q;
      OFF_TEMP: prdata[15:0] = {warn_thr_q, oh_thr_q};
      OFF_LL: prdata = {6'h00, ll_time_q, 6'h00, ll_lvl_q};
      OFF_OS: prdata = {6'h00, os_time_q, 6'h00, os_mar_q};
      OFF_DEV: prdata = {6'h00, dev_time_q, 6'h00, dev_mar_q};
      OFF_IRQ_STS: prdata[NEV-1:0] = sts_q;
      OFF_IRQ_MSK: prdata[NEV-1:0] = msk_q;
      OFF_STATE: prdata[19:0] = {ll_q, keep_running, method_stop,
                                 coast_stop, active};
      default: prdata = '0;
    endcase
  end

  // 0.1 s time base shared by all persistence timers
  always_ff @(posedge mclk) begin
    if (srst || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = tick_cnt_q == 32'(TICK - 1);

  // detector conditions
  assign os_off = pct_of(meas.max_freq, os_mar_q);
  assign dev_off = pct_of(meas.max_freq, dev_mar_q);
  assign dev = meas.speed > meas.set_freq ? meas.speed - meas.set_freq
                                          : meas.set_freq - meas.speed;
  assign os_cond = 17'(meas.speed) > 17'(meas.max_freq) + 17'(os_off);
  assign dev_cond = dev > dev_off; // [R15]
  assign ll_cond = ll_en_q && meas.current < ll_lvl_q; // [R11]
  assign oh_cond = sens_q != 2'h0 && meas.temp > oh_thr_q; // [R8] [R9]
  assign warn_cond = sens_q != 2'h0 && meas.temp > warn_thr_q; // [R10]

  dfs_persist #(.W(10)) u_ll (.mclk(mclk), .srst(srst), .tick(tick),
    .cond(ll_cond), .limit(ll_time_q), .zero_off(1'b0),
    .expired(ll_exp));
  dfs_persist #(.W(10)) u_os (.mclk(mclk), .srst(srst), .tick(tick),
    .cond(os_cond), .limit(os_time_q), .zero_off(1'b1),
    .expired(os_exp)); // [R13] [R14]
  dfs_persist #(.W(10)) u_dev (.mclk(mclk), .srst(srst), .tick(tick),
    .cond(dev_cond), .limit(dev_time_q), .zero_off(1'b1),
    .expired(dev_exp)); // [R15] [R16]

  // latched detector faults: 0 overheat, 1 overspeed, 2 deviation
  always_ff @(posedge mclk) begin
    if (srst) begin
      det_q <= '0;
    end else begin
      det_q <= (fault_clear ? 3'b000 : det_q) |
               {dev_exp, os_exp, oh_cond}; // [R9] [R13] [R15]
    end
  end

  // load loss: cut while light, back to the frequency chosen by sel_q when load returns
  always_ff @(posedge mclk) begin
    if (srst) begin
      ll_q <= LL_IDLE;
    end else begin
      case (ll_q)
        LL_IDLE: if (ll_exp) ll_q <= LL_CUT; // [R11]
        LL_CUT: if (!ll_cond) ll_q <= LL_IDLE; // [R12]
        default: ll_q <= LL_IDLE;
      endcase
    end
  end

  // fault sources and their action digits
  assign active = {det_q[0], faults.initial_position_fault, det_q[1],
                   det_q[2], faults.pid_feedback_lost_fault,
                   ll_q == LL_CUT, faults.power_on_time_expired_fault,
                   faults.user_fault_two, faults.user_fault_one,
                   faults.run_time_expired_fault, faults.nvm_fault,
                   faults.comm_fault, faults.external_fault,
                   faults.output_phase_loss_fault,
                   faults.input_phase_loss_fault,
                   faults.motor_overload_fault};

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      code[i] = digit(act_q[0], i); // [R2]
    end
    code[5] = digit(act_q[1], 1); // [R3]
    code[6] = digit(act_q[1], 4);
    code[7] = digit(act_q[2], 0); // [R4]
    code[8] = digit(act_q[2], 1);
    code[9] = digit(act_q[2], 2);
    // load loss has a digit in two groups; the harsher one wins
    code[10] = digit(act_q[2], 3) < digit(act_q[3], 3)
             ? digit(act_q[2], 3) : digit(act_q[3], 3); // [R5]
    code[11] = digit(act_q[2], 4);
    code[12] = digit(act_q[3], 0);
    code[13] = digit(act_q[3], 1);
    code[14] = digit(act_q[3], 2);
    code[15] = ACT_COAST;
    any_coast = 1'b0;
    any_stop = 1'b0;
    any_run = 1'b0;
    for (int i = 0; i < NFAULT; i++) begin
      if (active[i]) begin
        case (code[i])
          ACT_COAST: any_coast = 1'b1; // [R1]
          ACT_STOP: any_stop = 1'b1;
          default: any_run = 1'b1;
        endcase
      end
    end
  end

  assign stby_f = pct_of(meas.max_freq, stby_q); // [R7]
  assign ll_f = pct_of(meas.rated_freq, LL_CUT_PM); // [R11]

  always_ff @(posedge mclk) begin
    if (srst) begin
      coast_stop <= 1'b0;
      method_stop <= 1'b0;
      keep_running <= 1'b0;
      freq_ovr_valid <= 1'b0;
      freq_ovr <= '0;
      overheat_warn <= 1'b0;
    end else begin
      coast_stop <= any_coast;
      method_stop <= any_stop && !any_coast;
      keep_running <= any_run && !any_stop && !any_coast;
      freq_ovr_valid <= any_run && !any_stop && !any_coast;
      overheat_warn <= warn_cond; // [R10]
      if (ll_q == LL_CUT) begin
        freq_ovr <= ll_f; // [R11]
      end else begin
        case (sel_q)
          SEL_SET: freq_ovr <= meas.set_freq; // [R6]
          SEL_UPPER: freq_ovr <= meas.upper_freq;
          SEL_LOWER: freq_ovr <= meas.lower_freq;
          SEL_STBY: freq_ovr <= stby_f;
          default: freq_ovr <= meas.run_freq;
        endcase
      end
    end
  end

  // sticky events, set beats a write-one clear
  assign ev = {|(faults & ~flt_prev_q), os_exp & ~det_q[1],
               dev_exp & ~det_q[2], ll_exp && ll_q == LL_IDLE,
               warn_cond & ~overheat_warn, oh_cond & ~det_q[0]};

  always_ff @(posedge mclk) begin
    if (srst) begin
      sts_q <= '0;
      flt_prev_q <= '0;
    end else begin
      flt_prev_q <= faults;
      if (wr && paddr == OFF_IRQ_STS) begin
        sts_q <= (sts_q & ~pwdata[NEV-1:0]) | ev;
      end else begin
        sts_q <= sts_q | ev;
      end
    end
  end
  assign irq = |(sts_q & msk_q);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  coast_wins_a: assert property ( // [R1]
    any_coast |=> coast_stop && !keep_running)
    else $error("coast fault did not force coast stop");
  run_group_a: assert property ( // [R2]
    act_q[0][3:0] == 4'h2 && active == 16'h0001 |=> keep_running)
    else $error("overload digit 2 did not keep running");
  overheat_set_a: assert property ( // [R9]
    oh_cond |=> det_q[0] ##1 coast_stop)
    else $error("overheat did not latch a fault");
  warn_out_a: assert property (warn_cond |=> overheat_warn) // [R10]
    else $error("overheat warning missing");
  ll_cut_a: assert property ( // [R11]
    ll_q == LL_CUT |=> freq_ovr == $past(ll_f))
    else $error("load loss frequency cut wrong");
  ll_resume_a: assert property ( // [R12]
    ll_q == LL_CUT && !ll_cond |=> ll_q == LL_IDLE)
    else $error("load loss did not release on load return");
  os_off_a: assert property (os_time_q == '0 |-> !os_exp) // [R14]
    else $error("overspeed detected with zero time");
  dev_off_a: assert property (dev_time_q == '0 |-> !dev_exp) // [R16]
    else $error("deviation detected with zero time");
  standby_a: assert property ( // [R6]
    ll_q == LL_IDLE && sel_q == SEL_STBY |=> freq_ovr == $past(stby_f))
    else $error("standby frequency not selected");
  ll_enter_c: cover property (ll_q == LL_IDLE ##1 ll_q == LL_CUT);
  os_fault_c: cover property ($rose(det_q[1]));
  run_stby_c: cover property (keep_running && sel_q == SEL_STBY);
  irq_c: cover property ($rose(irq));
endmodule

// >>> verif/dfs_drive_model.sv
// Purpose: behavioural drive feedback seen by the fault supervisor
// Assumes: bench commands temperature, current and speed levels
// Notes: frequency limits fixed by parameters; one cycle sensing lag
`timescale 1ns/100ps
module dfs_drive_model
  import dfs_pkg::*;
#(
  parameter logic [15:0] MAXF = 16'd5000,
  parameter logic [15:0] UPF = 16'd4800,
  parameter logic [15:0] LOF = 16'd500,
  parameter logic [15:0] RATF = 16'd5000
) (
  // clock
  input wire logic mclk,
  // bench commands
  input wire logic [7:0] temp_c,
  input wire logic [9:0] cur_c,
  input wire logic [15:0] spd_c,
  input wire logic [15:0] set_c,
  // sensed values
  output dfs_meas_t meas
);
  // run frequency trails the set point so every selector differs
  always_ff @(posedge mclk) begin
    meas <= '{temp: temp_c, current: cur_c, speed: spd_c, set_freq: set_c,
      run_freq: set_c - 16'd100, max_freq: MAXF, upper_freq: UPF,
      lower_freq: LOF, rated_freq: RATF};
  end
endmodule

// >>> verif/drive_fault_supervisor_tb.sv
// Purpose: self-checking bench for the drive fault supervisor
// Assumes: TICK of 10 cycles, so one tenth of a second is 10 cycles
// Notes: action rows in a table; detectors and apb edges by hand
`timescale 1ns/100ps
module drive_fault_supervisor_tb;
  import dfs_pkg::*;
  typedef struct packed {
    logic [7:0] off;
    logic [2:0] dig;
    logic [3:0] fb;
    logic [1:0] code;
    logic [2:0] exp;
  } dfs_row_t;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fclr = 1'b0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr;
  dfs_fault_in_t flt = '0;
  dfs_meas_t meas;
  logic [7:0] temp_c = 8'd25;
  logic [9:0] cur_c = 10'd500;
  logic [15:0] spd_c = 16'd3000;
  logic coast_stop, method_stop, keep_running, freq_ovr_valid;
  logic overheat_warn, irq;
  logic [15:0] freq_ovr;
  logic [2:0] resp;
  logic [19:0] fill;
  int error_cnt = 0;
  int comparisons = 0;
  // current, set, upper, lower, standby at 50.0 percent of 5000
  logic [15:0] sel_exp [5] = '{16'd2900, 16'd3000, 16'd4800, 16'd500,
    16'd2500};
  dfs_row_t rows [12] = '{
    '{OFF_ACT1, 3'd0, 4'd11, 2'd2, 3'b001},
    '{OFF_ACT1, 3'd1, 4'd10, 2'd1, 3'b010},
    '{OFF_ACT1, 3'd2, 4'd9, 2'd2, 3'b001},
    '{OFF_ACT1, 3'd3, 4'd8, 2'd0, 3'b100},
    '{OFF_ACT1, 3'd4, 4'd7, 2'd1, 3'b010},
    '{OFF_ACT2, 3'd1, 4'd6, 2'd2, 3'b001},
    '{OFF_ACT2, 3'd4, 4'd5, 2'd1, 3'b010},
    '{OFF_ACT3, 3'd0, 4'd4, 2'd1, 3'b010},
    '{OFF_ACT3, 3'd1, 4'd3, 2'd2, 3'b001},
    '{OFF_ACT3, 3'd2, 4'd2, 2'd0, 3'b100},
    '{OFF_ACT3, 3'd4, 4'd1, 2'd1, 3'b010},
    '{OFF_ACT4, 3'd2, 4'd0, 2'd2, 3'b001}};

  always #5 mclk = ~mclk;

  assign resp = {coast_stop, method_stop, keep_running};

  dfs_drive_model dfs_drive_model_inst (.mclk(mclk), .temp_c(temp_c),
    .cur_c(cur_c), .spd_c(spd_c), .set_c(16'd3000), .meas(meas));

  dfs_supervisor #(.TICK(10)) dfs_supervisor_inst (.mclk(mclk),
    .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .faults(flt), .fault_clear(fclr),
    .coast_stop(coast_stop), .method_stop(method_stop),
    .keep_running(keep_running), .freq_ovr_valid(freq_ovr_valid),
    .freq_ovr(freq_ovr), .overheat_warn(overheat_warn), .irq(irq));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no local cap: only the watchdog may end a stuck access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t flag got %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t value got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk32(rdat, e);
  endtask

  task automatic pulse_clear();
    fclr <= 1'b1;
    cyc(1);
    fclr <= 1'b0;
    cyc(3);
  endtask

  // time 0 must disable, the boundary speed must not trip
  task automatic det(input logic [7:0] off, input int b,
                     input logic [15:0] ok_s, input logic [15:0] bad_s,
                     input logic [2:0] ex);
    wr(off, 32'h0000_00c8);
    spd_c <= bad_s;
    cyc(60);
    rd(OFF_STATE);
    chk1(rdat[b], 1'b0);
    wr(off, 32'h0002_00c8);
    spd_c <= ok_s;
    cyc(50);
    rd(OFF_STATE);
    chk1(rdat[b], 1'b0);
    spd_c <= bad_s;
    cyc(50);
    rd(OFF_STATE);
    chk1(rdat[b], 1'b1);
    chk32({29'h0, resp}, {29'h0, ex});
    spd_c <= 16'd3000;
    // sensed speed lags a cycle; a clear before it settles is overrun
    cyc(2);
    pulse_clear();
    rd(OFF_STATE);
    chk1(rdat[b], 1'b0);
  endtask

  task automatic complete_run();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] %0t watchdog ran out", $time);
    complete_run();
  end

  initial begin
    cyc(10);
    chk1(coast_stop | keep_running | irq, 1'b0);
    srst <= 1'b0;
    cyc(2);
    // other digits carry a different code so a misrouted digit shows
    for (int i = 0; i < 12; i++) begin
      fill = (rows[i].code == 2'd2) ? 20'h11111 : 20'h22222;
      fill[rows[i].dig*4 +: 4] = {2'b00, rows[i].code};
      wr(rows[i].off, {12'h0, fill});
      flt[rows[i].fb] <= 1'b1;
      cyc(3);
      chk32({29'h0, resp}, {29'h0, rows[i].exp});
      chk1(freq_ovr_valid, rows[i].exp[0]);
      if (rows[i].exp[0]) begin
        chk32({16'h0, freq_ovr}, {16'h0, sel_exp[0]});
      end
      flt <= '0;
      wr(rows[i].off, 32'h0);
    end
    rdchk(OFF_ACT2, 32'h0);
    rdchk(OFF_CFG, 32'h0);
    rdchk(OFF_STBY, 32'd1000);
    rdchk(OFF_TEMP, 32'h0000_5a6e);
    rdchk(OFF_LL, 32'h000a_0064);
    rdchk(OFF_OS, 32'h000a_00c8);
    rdchk(OFF_DEV, 32'h0032_00c8);
    rdchk(8'h34, 32'h0);
    chk1(rerr, 1'b1);
    rd(8'h02);
    chk1(rerr, 1'b1);
    wr(OFF_STATE, 32'hffff_ffff);
    rdchk(OFF_STATE, 32'h0);
    wr(OFF_ACT1, 32'h0000_2000);
    wr(OFF_STBY, 32'd500);
    flt.external_fault <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      wr(OFF_CFG, 32'(s));
      cyc(3);
      chk32({16'h0, freq_ovr}, {16'h0, sel_exp[s]});
    end
    flt <= '0;
    wr(OFF_ACT1, 32'h0);
    wr(OFF_CFG, 32'h0);
    temp_c <= 8'd150;
    cyc(4);
    chk1(overheat_warn | coast_stop, 1'b0);
    // cool first so enabling the sensor does not latch a fault
    temp_c <= 8'd90;
    wr(OFF_CFG, 32'h10);
    cyc(4);
    chk1(overheat_warn, 1'b0);
    temp_c <= 8'd91;
    cyc(4);
    chk1(overheat_warn, 1'b1);
    temp_c <= 8'd110;
    cyc(4);
    chk1(coast_stop, 1'b0);
    temp_c <= 8'd111;
    cyc(4);
    chk1(coast_stop, 1'b1);
    wr(OFF_IRQ_MSK, 32'h08);
    cyc(1);
    chk1(irq, 1'b0);
    wr(OFF_IRQ_MSK, 32'h01);
    cyc(1);
    chk1(irq, 1'b1);
    temp_c <= 8'd25;
    cyc(4);
    chk1(coast_stop, 1'b1);
    pulse_clear();
    chk1(coast_stop, 1'b0);
    wr(OFF_IRQ_STS, 32'h3f);
    cyc(1);
    chk1(irq, 1'b0);
    wr(OFF_IRQ_MSK, 32'h0);
    wr(OFF_LL, 32'h0003_0064);
    wr(OFF_CFG, 32'h100);
    cur_c <= 10'd50;
    cyc(15);
    cur_c <= 10'd200;
    cyc(5);
    cur_c <= 10'd50;
    cyc(12);
    rd(OFF_STATE);
    chk1(rdat[19], 1'b0);
    cyc(40);
    rd(OFF_STATE);
    chk1(rdat[19], 1'b1);
    chk32({16'h0, freq_ovr}, 32'd5000 * 7 / 100);
    cur_c <= 10'd200;
    cyc(4);
    rd(OFF_STATE);
    chk1(rdat[19], 1'b0);
    wr(OFF_CFG, 32'h0);
    cur_c <= 10'd500;
    wr(OFF_DEV, 32'h0000_00c8);
    wr(OFF_ACT4, 32'h0000_0010);
    det(OFF_OS, 13, 16'd6000, 16'd6001, 3'b010);
    wr(OFF_ACT4, 32'h0000_0002);
    det(OFF_DEV, 12, 16'd4000, 16'd1999, 3'b001);
    complete_run();
  end
endmodule
